/* File: hw/hmpc_pkg.sv */
// Package: constants, types and helpers of the hardware-mode pin configuration
`default_nettype none

package hmpc_pkg;

  // ==========================================================
  // Port interface select codes
  localparam logic [1:0] IF_HARDWARE = 2'h0;
  localparam logic [1:0] IF_SERIAL = 2'h1;
  localparam logic [1:0] IF_PARALLEL = 2'h2;
  localparam logic [1:0] IF_PARALLEL_MUX = 2'h3;

  // ==========================================================
  // Transmit clock sources and termination codes
  typedef enum logic [1:0] {
    TXCK_EXT = 2'h0,
    TXCK_PLL = 2'h1,
    TXCK_MCLK = 2'h2,
    TXCK_RCLK = 2'h3
  } hmpc_txck_t;

  typedef enum logic [1:0] {
    TERM_OFF = 2'h0,
    TERM_NATIVE = 2'h1,
    TERM_E1_75 = 2'h2,
    TERM_E1_120 = 2'h3
  } hmpc_term_t;

  // ==========================================================
  // Strap sampling states
  typedef enum logic [1:0] {
    ST_SETTLE = 2'h1,
    ST_HELD = 2'h2
  } hmpc_strap_st_t;

  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // ==========================================================
  // Register word indices
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_STRAPS = 2'h2;
  localparam logic [1:0] REG_CMD = 2'h3;

  // Control register fields
  localparam int CTRL_TXCK_LSB = 0;
  localparam int CTRL_CODING = 2;
  localparam int CTRL_LOOPBACK = 3;
  localparam int CTRL_TX_TERM_DIS = 4;
  localparam int CTRL_RX_TERM_DIS = 5;
  localparam int CTRL_E1_120 = 6;
  localparam int CTRL_JA_SEL0 = 7;
  localparam int CTRL_RXMODE_LSB = 8;
  localparam int CTRL_TXMODE_LSB = 12;
  localparam int CTRL_PLL_RCLK = 16;
  localparam logic [16:0] CTRL_RESET = 17'h00000;
  localparam int CMD_RESAMPLE = 0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] portIfSel;
    logic [7:0] addrDataIn;
    logic [7:0] addrIn;
    logic busStrobeStyleSel;
    logic chipSelN;
    logic readStrobeN;
    logic writeStrobeN;
    logic intPinIn;
    logic txClkSrcSelHi;
    logic txModeSelB1;
    logic txModeSelB2;
  } hmpc_pin_in_t;

  typedef struct packed {
    logic [7:0] addrDataOut;
    logic [7:0] addrDataOe;
    logic intPinOut;
    logic intPinOe;
  } hmpc_pin_out_t;

  typedef struct packed {
    logic chipSelN;
    logic readStrobeN;
    logic writeStrobeN;
    logic busStrobeStyleSel;
    logic [7:0] addrDataIn;
    logic [7:0] addrIn;
    logic serialClock;
    logic serialDataIn;
  } hmpc_host_port_t;

  typedef struct packed {
    hmpc_txck_t txClkSrc;
    logic pllRefRecovered;
    logic lineCodingEnable;
    logic remoteLoopbackEn;
    hmpc_term_t txTerm;
    hmpc_term_t rxTerm;
    logic jitterAttClkSel0;
    logic [3:0] rxMode;
    logic [3:0] txMode;
  } hmpc_cfg_t;

  localparam hmpc_host_port_t HOST_PORT_IDLE = '{chipSelN: 1'b1,
    readStrobeN: 1'b1, writeStrobeN: 1'b1, default: '0};

  // ==========================================================
  // Helpers
  function automatic logic isE1Mode(input logic [3:0] mode);
    return (mode[3:2] == 2'h1) || (mode == 4'h8);
  endfunction

  function automatic hmpc_term_t termCode(input logic disable_,
      input logic [3:0] mode, input logic sel120);
    if (disable_) begin
      return TERM_OFF;
    end
    if (isE1Mode(mode)) begin
      return sel120 ? TERM_E1_120 : TERM_E1_75;
    end
    return TERM_NATIVE;
  endfunction

endpackage

`default_nettype wire

/* File: hw/hmpc_sync2.sv */
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module hmpc_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } hmpc_sync_state_t;

  hmpc_sync_state_t q;
  hmpc_sync_state_t d;

  // ==========================================================
  // Next state
  always_comb begin
    d.stage1 = async;
    d.stage2 = q.stage1;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign synced = q.stage2;

endmodule

`default_nettype wire

/* File: hw/hmpc_tx_clock_select.sv */
// Transmit clock, PLL output and PLL reference selection
`timescale 1ns/1ps
`default_nettype none

module hmpc_tx_clock_select (
  input wire hmpc_pkg::hmpc_txck_t txClkSrc,
  input wire logic hardwareMode,
  input wire logic pllRefRecovered,
  input wire logic extTxClockIn,
  input wire logic pllClk,
  input wire logic mclkScaled,
  input wire logic rxRecoveredClk,
  output logic txClock,
  output logic pllOut,
  output logic txPllRef
);
  import hmpc_pkg::*;

  // ==========================================================
  // Source mux
  always_comb begin
    case (txClkSrc)
      TXCK_EXT: txClock = extTxClockIn;
      TXCK_PLL: txClock = pllClk;
      TXCK_MCLK: txClock = mclkScaled;
      TXCK_RCLK: txClock = rxRecoveredClk;
      default: txClock = extTxClockIn;
    endcase
  end

  assign pllOut = txClock;

  // ==========================================================
  // PLL reference
  always_comb begin
    if (hardwareMode) begin
      txPllRef = extTxClockIn;
    end else begin
      txPllRef = pllRefRecovered ? rxRecoveredClk : extTxClockIn;
    end
  end

endmodule

`default_nettype wire

/* File: hw/hmpc_pin_config.sv */
// Top: port-interface select, shared pin routing and strap decoding
`timescale 1ns/1ps
`default_nettype none

// Function
// - Two select pins choose parallel, serial or strap control; shared pins follow.
// - Strap control turns host address, data and strobe pins into function selects.
// - Strap control offers a subset; other functions sit at fixed states.
// - Strap control always feeds the transmit PLL from the external clock pin.
// - Source straps pick external, PLL, scaled master or recovered clock.
// - PLL output pin carries the same signal as the chosen transmit clock.
// - Strap control derives terminations from transmit and receive mode straps.
// - Transmit termination on when its disable strap is 0, off at 1.
// - Receive termination on when its disable strap is 0, off at 1.
// - E1 with termination on: strap 0 gives 75 ohm, 1 gives 120 ohm.
// - Bus-type pin picks strobe style in parallel, line coding in straps.
// - Select pin is active-low chip select in host modes, loopback in straps.
// - Read and write strobes in parallel mode; receive/transmit mode bits in straps.
// - Serial mode: data out on bit 0 pin, data in on bit 1 pin.
// - Shared pin is interrupt in host modes, jitter clock select 0 in straps.
// - Dedicated pins give source bit 1 and transmit mode bits 1 and 2.
// - Signal loss and frame loss indications drive their pins in every mode.
// - Address/data bits 4 to 7 carry receive mode 0,1 and termination disables.
module hmpc_pin_config (
  input wire logic clock,
  input wire logic rst_n,
  input wire hmpc_pkg::hmpc_pin_in_t pinIn,
  input wire logic extTxClockIn,
  input wire logic pllClk,
  input wire logic mclkScaled,
  input wire logic rxRecoveredClk,
  input wire logic [7:0] hostAdOut,
  input wire logic [7:0] hostAdOe,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  input wire logic hostIrq,
  input wire logic rxLos,
  input wire logic rxLof,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output hmpc_pkg::hmpc_pin_out_t pinOut,
  output hmpc_pkg::hmpc_host_port_t hostPort,
  output hmpc_pkg::hmpc_cfg_t cfg,
  output logic hardwareMode,
  output logic strapValid,
  output logic txClock,
  output logic pllOut,
  output logic txPllRef,
  output logic rxSignalLossOut,
  output logic rxFrameLossCcErrOut
);
  import hmpc_pkg::*;

  typedef struct packed {
    hmpc_strap_st_t strapSt;
    logic [1:0] settleCnt;
    hmpc_pin_in_t straps;
    logic [16:0] ctrl;
    logic ack;
    logic [31:0] readData;
    hmpc_cfg_t cfg;
    hmpc_host_port_t hostPort;
    hmpc_pin_out_t pinOut;
    logic hwMode;
    logic los;
    logic lof;
  } hmpc_state_t;

  hmpc_state_t q;
  hmpc_state_t d;
  hmpc_pin_in_t pinSync;
  logic request;
  logic writeTaken;
  logic resampleReq;
  logic held;
  logic [1:0] ifMode;

  // ==========================================================
  // Pin input synchronisers
  hmpc_sync2 #(
    .W($bits(hmpc_pin_in_t))
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async(pinIn),
    .synced(pinSync)
  );

  // ==========================================================
  // Bus strobes
  assign request = avs_read | avs_write;
  assign writeTaken = avs_write & q.ack;
  assign resampleReq = writeTaken && (avs_address == REG_CMD) &&
                       avs_writedata[CMD_RESAMPLE];
  assign held = (q.strapSt == ST_HELD);
  assign ifMode = q.straps.portIfSel;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.ack = request & ~q.ack;

    // Strap capture after reset release
    case (q.strapSt)
      ST_SETTLE: begin
        if (q.settleCnt == STRAP_SETTLE_CYCLES) begin
          d.straps = pinSync;
          d.strapSt = ST_HELD;
        end else begin
          d.settleCnt = q.settleCnt + 2'h1;
        end
      end
      ST_HELD: begin
        if (resampleReq) begin
          d.strapSt = ST_SETTLE;
          d.settleCnt = '0;
        end
      end
      default: begin
        d.strapSt = ST_SETTLE;
        d.settleCnt = '0;
      end
    endcase

    // Host-mode control register
    if (writeTaken && (avs_address == REG_CTRL)) begin
      d.ctrl = avs_writedata[16:0];
    end

    d.hwMode = held && (ifMode == IF_HARDWARE);

    // Decoded selections
    if (d.hwMode) begin
      d.cfg.txClkSrc = hmpc_txck_t'({q.straps.txClkSrcSelHi,
                                     q.straps.addrDataIn[0]});
      d.cfg.pllRefRecovered = 1'b0;
      d.cfg.lineCodingEnable = q.straps.busStrobeStyleSel;
      d.cfg.remoteLoopbackEn = q.straps.chipSelN;
      d.cfg.jitterAttClkSel0 = q.straps.intPinIn;
      d.cfg.rxMode = {q.straps.addrDataIn[1], q.straps.readStrobeN,
                      q.straps.addrDataIn[5:4]};
      d.cfg.txMode = {q.straps.writeStrobeN, q.straps.txModeSelB2,
                      q.straps.txModeSelB1, q.straps.addrIn[5]};
      d.cfg.txTerm = termCode(q.straps.addrDataIn[6], d.cfg.txMode,
                              q.straps.addrIn[0]);
      d.cfg.rxTerm = termCode(q.straps.addrDataIn[7], d.cfg.rxMode,
                              q.straps.addrIn[0]);
    end else begin
      d.cfg.txClkSrc = hmpc_txck_t'(q.ctrl[CTRL_TXCK_LSB +: 2]);
      d.cfg.pllRefRecovered = q.ctrl[CTRL_PLL_RCLK];
      d.cfg.lineCodingEnable = q.ctrl[CTRL_CODING];
      d.cfg.remoteLoopbackEn = q.ctrl[CTRL_LOOPBACK];
      d.cfg.jitterAttClkSel0 = q.ctrl[CTRL_JA_SEL0];
      d.cfg.rxMode = q.ctrl[CTRL_RXMODE_LSB +: 4];
      d.cfg.txMode = q.ctrl[CTRL_TXMODE_LSB +: 4];
      d.cfg.txTerm = termCode(q.ctrl[CTRL_TX_TERM_DIS], d.cfg.txMode,
                              q.ctrl[CTRL_E1_120]);
      d.cfg.rxTerm = termCode(q.ctrl[CTRL_RX_TERM_DIS], d.cfg.rxMode,
                              q.ctrl[CTRL_E1_120]);
    end

    // Shared pin routing; strap mode leaves host port idle
    d.hostPort = HOST_PORT_IDLE;
    d.pinOut = '0;
    if (held) begin
      case (ifMode)
        IF_PARALLEL, IF_PARALLEL_MUX: begin
          d.hostPort.chipSelN = pinSync.chipSelN;
          d.hostPort.readStrobeN = pinSync.readStrobeN;
          d.hostPort.writeStrobeN = pinSync.writeStrobeN;
          d.hostPort.busStrobeStyleSel = pinSync.busStrobeStyleSel;
          d.hostPort.addrDataIn = pinSync.addrDataIn;
          d.hostPort.addrIn = pinSync.addrIn;
          d.pinOut.addrDataOut = hostAdOut;
          d.pinOut.addrDataOe = hostAdOe;
          d.pinOut.intPinOe = hostIrq;
        end
        IF_SERIAL: begin
          d.hostPort.chipSelN = pinSync.chipSelN;
          d.hostPort.serialClock = pinSync.addrDataIn[2];
          d.hostPort.serialDataIn = pinSync.addrDataIn[1];
          d.pinOut.addrDataOut[0] = spiMiso;
          d.pinOut.addrDataOe[0] = spiMisoOe & ~pinSync.chipSelN;
          d.pinOut.intPinOe = hostIrq;
        end
        default: begin
          d.pinOut = '0;
        end
      endcase
    end

    d.los = rxLos;
    d.lof = rxLof;

    // Read data, loaded one cycle before the answer
    d.readData = '0;
    if (avs_read & ~q.ack) begin
      case (avs_address)
        REG_CTRL: d.readData = {15'h0000, q.ctrl};
        REG_STATUS: d.readData = {8'h00, q.cfg.txMode, q.cfg.rxMode,
          q.lof, q.los, q.cfg.jitterAttClkSel0, q.cfg.rxTerm,
          q.cfg.txTerm, q.cfg.remoteLoopbackEn, q.cfg.lineCodingEnable,
          q.cfg.pllRefRecovered, q.cfg.txClkSrc, held, q.hwMode, ifMode};
        REG_STRAPS: d.readData = {6'h00, q.straps};
        default: d.readData = '0;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
      q.strapSt <= ST_SETTLE;
      q.ctrl <= CTRL_RESET;
      q.hostPort <= HOST_PORT_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Transmit clocking
  hmpc_tx_clock_select u_clksel (
    .txClkSrc(q.cfg.txClkSrc),
    .hardwareMode(q.hwMode),
    .pllRefRecovered(q.cfg.pllRefRecovered),
    .extTxClockIn(extTxClockIn),
    .pllClk(pllClk),
    .mclkScaled(mclkScaled),
    .rxRecoveredClk(rxRecoveredClk),
    .txClock(txClock),
    .pllOut(pllOut),
    .txPllRef(txPllRef)
  );

  // ==========================================================
  // Outputs
  assign avs_waitrequest = request & ~q.ack;
  assign avs_readdata = q.readData;
  assign pinOut = q.pinOut;
  assign hostPort = q.hostPort;
  assign cfg = q.cfg;
  assign hardwareMode = q.hwMode;
  assign strapValid = held;
  assign rxSignalLossOut = q.los;
  assign rxFrameLossCcErrOut = q.lof;

endmodule

`default_nettype wire

/* File: test/hmpc_pin_config_chk.sv */
// Assertion checker bound to the pin configuration top
`timescale 1ns/1ps
`default_nettype none
module hmpc_pin_config_chk
  import hmpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic extTxClockIn,
  input wire logic pllClk,
  input wire logic mclkScaled,
  input wire logic rxRecoveredClk,
  input wire logic hostIrq,
  input wire logic rxLos,
  input wire logic rxLof,
  input wire hmpc_pkg::hmpc_pin_out_t pinOut,
  input wire hmpc_pkg::hmpc_host_port_t hostPort,
  input wire hmpc_pkg::hmpc_cfg_t cfg,
  input wire logic hardwareMode,
  input wire logic strapValid,
  input wire logic txClock,
  input wire logic pllOut,
  input wire logic txPllRef,
  input wire logic rxSignalLossOut,
  input wire logic rxFrameLossCcErrOut
);
  // ====================================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_PLL_SAME: assert property (pllOut == txClock)
    else $error("pll output differs from tx clock");
  AST_TXCK_MUX: assert property (txClock == (cfg.txClkSrc == TXCK_EXT ?
    extTxClockIn : cfg.txClkSrc == TXCK_PLL ? pllClk :
    cfg.txClkSrc == TXCK_MCLK ? mclkScaled : rxRecoveredClk))
    else $error("tx clock is not the selected source");
  AST_HW_PLL_REF: assert property (hardwareMode && $past(hardwareMode)
    |-> txPllRef == extTxClockIn) else $error("pll reference not ext clock");
  AST_LOSS_PIPE: assert property ($past(rst_n) |->
    rxSignalLossOut == $past(rxLos) && rxFrameLossCcErrOut == $past(rxLof))
    else $error("loss outputs do not follow inputs");
  AST_HW_PINS_OFF: assert property (hardwareMode && $past(hardwareMode) &&
    $past(hardwareMode, 2) |-> pinOut.addrDataOe == 8'h00 && !pinOut.intPinOe)
    else $error("shared pins driven in strap mode");
  AST_HW_PORT_IDLE: assert property (hardwareMode && $past(hardwareMode) &&
    $past(hardwareMode, 2) |-> hostPort == HOST_PORT_IDLE)
    else $error("host port not idle in strap mode");
  AST_HW_STATIC: assert property (hardwareMode && $past(hardwareMode) &&
    $past(hardwareMode, 2) |-> $stable(cfg)) else $error("strap config moved");
  AST_INT_OD: assert property (strapValid && $past(strapValid) &&
    $past(strapValid, 2) && !hardwareMode |-> !pinOut.intPinOut &&
    pinOut.intPinOe == $past(hostIrq)) else $error("interrupt pin wrong");
  AST_SETTLE: assert property ($rose(rst_n) |->
    !strapValid [*3] ##[1:4] strapValid) else $error("strap capture late");
endmodule
bind hmpc_pin_config hmpc_pin_config_chk chk_u (.clock, .rst_n, .extTxClockIn,
  .pllClk, .mclkScaled, .rxRecoveredClk, .hostIrq, .rxLos, .rxLof, .pinOut,
  .hostPort, .cfg, .hardwareMode, .strapValid, .txClock, .pllOut, .txPllRef,
  .rxSignalLossOut, .rxFrameLossCcErrOut);
`default_nettype wire

/* File: test/hmpc_board_model.sv */
// Board model: strap pins, shared pin wiring and clock sources
`timescale 1ns/1ps
`default_nettype none
module hmpc_board_model
  import hmpc_pkg::*;
(
  input wire hmpc_pkg::hmpc_pin_in_t want,
  input wire hmpc_pkg::hmpc_pin_out_t pinOut,
  input wire logic linkRcvd,
  output hmpc_pkg::hmpc_pin_in_t pinIn,
  output logic extTxClockIn,
  output logic pllClk,
  output logic mclkScaled,
  output logic rxRecoveredClk
);
  // ====================================================
  // Oscillators and pin resolution
  logic oscExt;
  initial begin
    oscExt = 1'b0;
    pllClk = 1'b0;
    mclkScaled = 1'b0;
    rxRecoveredClk = 1'b0;
  end
  always #5 oscExt = ~oscExt;
  always #7 pllClk = ~pllClk;
  always #9 mclkScaled = ~mclkScaled;
  always #11 rxRecoveredClk = ~rxRecoveredClk;
  assign extTxClockIn = linkRcvd ? rxRecoveredClk : oscExt;
  always_comb begin
    pinIn = want;
    if (want.portIfSel != IF_HARDWARE) begin
      pinIn.txClkSrcSelHi = 1'b0;
      pinIn.txModeSelB1 = 1'b0;
      pinIn.txModeSelB2 = 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      if (pinOut.addrDataOe[i]) begin
        pinIn.addrDataIn[i] = pinOut.addrDataOut[i];
      end
    end
    if (pinOut.intPinOe) begin
      pinIn.intPinIn = pinOut.intPinOut;
    end
  end
endmodule
`default_nettype wire

/* File: test/hmpc_pin_config_bench.sv */
// Self-checking bench of the pin configuration top
`timescale 1ns/1ps
`default_nettype none
module hmpc_pin_config_bench;
  import hmpc_pkg::*;
  // ====================================================
  // Signals and strap table
  typedef struct packed {
    logic [7:0] ad;
    logic [7:0] a;
    logic [7:0] misc;
    hmpc_term_t tx;
    hmpc_term_t rx;
  } hmpc_row_t;
  logic clock, rst_n, linkRcvd, hostIrq, rxLos, rxLof, spiMiso, spiMisoOe;
  logic [7:0] hostAdOut, hostAdOe;
  logic [1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, hardwareMode, strapValid;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic txClock, pllOut, txPllRef, rxSignalLossOut, rxFrameLossCcErrOut;
  logic extTxClockIn, pllClk, mclkScaled, rxRecoveredClk;
  hmpc_pin_in_t want, pinIn, p;
  hmpc_pin_out_t pinOut;
  hmpc_host_port_t hostPort;
  hmpc_cfg_t cfg, expc;
  int num_errors, checks;
  hmpc_row_t rows [5] = '{
    '{8'h00, 8'h00, 8'h00, TERM_NATIVE, TERM_NATIVE},
    '{8'h41, 8'h00, 8'h00, TERM_OFF, TERM_NATIVE},
    '{8'h00, 8'h00, 8'ha5, TERM_E1_75, TERM_E1_75},
    '{8'h83, 8'h01, 8'h5c, TERM_E1_120, TERM_OFF},
    '{8'h12, 8'h21, 8'h03, TERM_E1_120, TERM_NATIVE}};
  hmpc_pin_config dut_u (.clock, .rst_n, .pinIn, .extTxClockIn, .pllClk,
    .mclkScaled, .rxRecoveredClk, .hostAdOut, .hostAdOe, .spiMiso, .spiMisoOe,
    .hostIrq, .rxLos, .rxLof, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pinOut, .hostPort, .cfg,
    .hardwareMode, .strapValid, .txClock, .pllOut, .txPllRef,
    .rxSignalLossOut, .rxFrameLossCcErrOut);
  hmpc_board_model board_u (.want, .pinOut, .linkRcvd, .pinIn, .extTxClockIn,
    .pllClk, .mclkScaled, .rxRecoveredClk);
  // ====================================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task strap(input hmpc_pin_in_t v);
    int n;
    @(posedge clock);
    want <= v;
    cyc(4);
    bus(1'b1, REG_CMD, 32'h1);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((strapValid !== 1'b1 || n < 3) && n < 40);
    if (n >= 40) num_errors++;
    cyc(3);
    #1;
  endtask
  task complete_run;
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ====================================================
  // Stimulus
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #40000;
    num_errors++;
    complete_run();
  end
  initial begin
    {rst_n, linkRcvd, hostIrq, rxLos, rxLof, spiMiso, spiMisoOe} = '0;
    {hostAdOut, hostAdOe, avs_address, avs_read, avs_write} = '0;
    avs_writedata = '0;
    want = '0;
    num_errors = 0;
    checks = 0;
    cyc(4);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk({strapValid, hostPort}, {1'b0, HOST_PORT_IDLE});
    foreach (rows[i]) begin
      p = '0;
      p.addrDataIn = rows[i].ad;
      p.addrIn = rows[i].a;
      {p.busStrobeStyleSel, p.chipSelN, p.readStrobeN, p.writeStrobeN,
        p.intPinIn, p.txClkSrcSelHi, p.txModeSelB1, p.txModeSelB2} = rows[i].misc;
      strap(p);
      expc = '{hmpc_txck_t'({p.txClkSrcSelHi, p.addrDataIn[0]}), 1'b0,
        p.busStrobeStyleSel, p.chipSelN, rows[i].tx, rows[i].rx, p.intPinIn,
        {p.addrDataIn[1], p.readStrobeN, p.addrDataIn[5:4]},
        {p.writeStrobeN, p.txModeSelB2, p.txModeSelB1, p.addrIn[5]}};
      chk(32'(cfg), 32'(expc));
      chk(hardwareMode, 1'b1);
    end
    p.addrDataIn = ~p.addrDataIn;
    @(posedge clock);
    want <= p;
    cyc(8);
    #1;
    chk(32'(cfg), 32'(expc));
    p = '0;
    p.portIfSel = IF_PARALLEL;
    p.readStrobeN = 1'b1;
    p.busStrobeStyleSel = 1'b1;
    p.intPinIn = 1'b1;
    p.txClkSrcSelHi = 1'b1;
    p.addrIn = 8'h3c;
    @(posedge clock);
    {hostAdOut, hostAdOe} <= 16'h5aff;
    {hostIrq, rxLos} <= 2'h3;
    strap(p);
    bus(1'b1, REG_CTRL, 32'h0001_54eb);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0001_54eb);
    expc = '{TXCK_RCLK, 1'b1, 1'b0, 1'b1, TERM_E1_120, TERM_OFF, 1'b1, 4'h4, 4'h5};
    chk(32'(cfg), 32'(expc));
    chk({hostPort.chipSelN, hostPort.readStrobeN, hostPort.writeStrobeN}, 3'h2);
    chk({hostPort.busStrobeStyleSel, hostPort.addrDataIn, hostPort.addrIn},
      17'h15a3c);
    chk({pinOut.addrDataOe, pinOut.addrDataOut}, 16'hff5a);
    chk({pinOut.intPinOut, pinOut.intPinOe}, 2'h1);
    chk({rxSignalLossOut, rxFrameLossCcErrOut}, 2'h2);
    @(rxRecoveredClk);
    #1;
    chk(txPllRef, rxRecoveredClk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:0], 4'ha);
    bus(1'b1, REG_STRAPS, 32'h0);
    bus(1'b0, REG_STRAPS, 32'h0);
    chk({rd[25:24], rd[2]}, 3'h4);
    p.portIfSel = IF_SERIAL;
    p.addrDataIn = 8'h06;
    @(posedge clock);
    hostAdOe <= 8'h00;
    {spiMiso, spiMisoOe, hostIrq, rxLos, rxLof} <= 5'h19;
    strap(p);
    chk({pinOut.addrDataOe[0], pinOut.addrDataOut[0], hostPort.serialDataIn}, 3'h7);
    chk({hostPort.chipSelN, pinOut.intPinOe, rxFrameLossCcErrOut}, 3'h1);
    chk(hostPort.serialClock, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:0], 3'h1);
    p.portIfSel = IF_PARALLEL_MUX;
    strap(p);
    chk({hostPort.writeStrobeN, hostPort.addrDataIn}, 9'h006);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:0], 4'hb);
    strap('0);
    @(posedge clock);
    linkRcvd <= 1'b1;
    repeat (12) begin
      @(rxRecoveredClk);
      #1;
      chk({pllOut, txPllRef}, {2{rxRecoveredClk}});
    end
    @(posedge clock);
    rst_n <= 1'b0;
    cyc(2);
    #1;
    chk({strapValid, cfg}, 32'h0);
    @(posedge clock);
    rst_n <= 1'b1;
    cyc(9);
    chk(strapValid, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
